// ### tap_pkg.sv
// Shared types and constants for the boundary-scan test access port.
package tap_pkg;

   // ************************************************************
   // Controller states
   // ************************************************************
   typedef enum logic [3:0]
   {
      test_logic_reset,
      run_test_idle,
      select_dr_scan,
      capture_dr,
      shift_dr,
      exit1_dr,
      pause_dr,
      exit2_dr,
      update_dr,
      select_ir_scan,
      capture_ir,
      shift_ir,
      exit1_ir,
      pause_ir,
      exit2_ir,
      update_ir
   } tap_state_t;

   // ************************************************************
   // Instruction register
   // ************************************************************
   localparam int IR_WIDTH = 3;
   localparam logic [IR_WIDTH-1:0] INSTR_EXTEST = 3'h0;
   localparam logic [IR_WIDTH-1:0] INSTR_SAMPLE = 3'h4;
   localparam logic [IR_WIDTH-1:0] INSTR_IDCODE = 3'h6;
   localparam logic [IR_WIDTH-1:0] INSTR_BYPASS = 3'h7;
   localparam logic [IR_WIDTH-1:0] IR_CAPTURE_VALUE = 3'h4;

   // ************************************************************
   // Data registers and pin sampling
   // ************************************************************
   localparam int BSR_LENGTH = 98;
   localparam int ID_WIDTH = 32;
   localparam int SYNC_STAGES = 3;
   localparam int LINK_PINS = 3;
   localparam int PIN_TCK = 2;
   localparam int PIN_TMS = 1;
   localparam int PIN_TDI = 0;

   // ************************************************************
   // Link pin groups
   // ************************************************************
   typedef struct packed
   {
      logic tck;
      logic tms;
      logic tdi;
   } link_in_t;

   typedef struct packed
   {
      logic tdo;
      logic tdo_oe;
   } link_out_t;

endpackage

// ### pin_sync.sv
// Three-stage synchroniser with agreement filter and edge pulses.
`timescale 1ns/100ps
module pin_sync
#(
   parameter int WIDTH = 3
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [WIDTH-1:0] raw,
   output logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise,
   output logic [WIDTH-1:0] fall
);
   import tap_pkg::*;

   // ************************************************************
   // One synchroniser per pin
   // ************************************************************
   // The first stage is read only by the second; a change counts once stages two and three agree.
   for (genvar i = 0; i < WIDTH; i++)
   begin : g_pin
      logic [SYNC_STAGES-1:0] stage;
      always_ff @(posedge clk)
      begin
         if (!rstn)
         begin
            stage <= '0;
            level[i] <= 1'b0;
         end
         else
         begin
            stage <= {stage[SYNC_STAGES-2:0], raw[i]};
            if (stage[1] == stage[2])
            begin
               level[i] <= stage[2];
            end
         end
      end
      assign rise[i] = stage[1] & stage[2] & ~level[i];
      assign fall[i] = ~stage[1] & ~stage[2] & level[i];
   end

   if (WIDTH < 1)
   begin : g_check
      $error("pin_sync needs at least one pin");
   end
endmodule

// ### boundary_scan_reg.sv
// Boundary scan shift chain with latched parallel output.
`timescale 1ns/100ps
module boundary_scan_reg
#(
   parameter int LENGTH = 98
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic capture,
   input wire logic shift,
   input wire logic update,
   input wire logic tdi,
   input wire logic [LENGTH-1:0] pins_in,
   output logic serial_out,
   output logic [LENGTH-1:0] pins_out
);
   import tap_pkg::*;

   logic [LENGTH-1:0] stage;

   // ************************************************************
   // Shift stages and output latch, one cell per bit
   // ************************************************************
   for (genvar i = 0; i < LENGTH; i++)
   begin : g_cell
      logic shift_in;
      if (i == LENGTH - 1)
      begin : g_top
         assign shift_in = tdi;
      end
      else
      begin : g_mid
         assign shift_in = stage[i+1];
      end
      always_ff @(posedge clk)
      begin
         if (!rstn)
         begin
            stage[i] <= 1'b0;
         end
         else if (capture)
         begin
            stage[i] <= pins_in[i];
         end
         else if (shift)
         begin
            stage[i] <= shift_in;
         end
      end
      // The latch moves only on update, so pins stay quiet while a pattern shifts through.
      always_ff @(posedge clk)
      begin
         if (!rstn)
         begin
            pins_out[i] <= 1'b0;
         end
         else if (update)
         begin
            pins_out[i] <= stage[i];
         end
      end
   end

   assign serial_out = stage[0];

   if (LENGTH < 2)
   begin : g_check
      $error("boundary_scan_reg needs at least two cells");
   end
endmodule

// ### jtag_tap_state_machine.sv
// Boundary-scan test access port controller with its instruction and data registers.
`timescale 1ns/100ps
// How it works
// - Reset state disables test logic, loads identify
// - Five high TMS edges always reach reset
// - Power-up reset enters reset state without TCK
// - Idle holds on low, high goes select-DR
// - Select-DR: low captures, high selects IR
// - Capture-DR samples pins for extest or sample
// - Capture-DR: high exit1, low shift
// - Shift-DR moves selected register toward TDO
// - Exit1-DR: high update, low pause
// - Pause-DR holds while low, high exit2
// - Exit2-DR: high update, low shift again
// - Update-DR latches scan output on falling edge
// - Select-IR: low captures, high returns reset
// - Capture-IR loads fixed pattern 100
// - Capture-IR: high exit1, low shift
// - Shift-IR moves instruction toward TDO
// - Exit1-IR: high update, low pause
// - Temporary states keep instruction and data
// - Three-bit instruction, LSB first, four codes
// - Update-IR latches instruction on falling edge
module jtag_tap_state_machine
#(
   parameter int BSR_BITS = tap_pkg::BSR_LENGTH,
   // Arbitrary identification value; bit 0 must stay set.
   parameter logic [31:0] ID_CODE = 32'h0a5c_3001
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire tap_pkg::link_in_t link_in,
   output tap_pkg::link_out_t link_out,
   input wire logic [BSR_BITS-1:0] pins_in,
   output logic [BSR_BITS-1:0] pins_out,
   output logic ext_test,
   output tap_pkg::tap_state_t tap_state
);
   import tap_pkg::*;

   // ************************************************************
   // Declarations
   // ************************************************************
   tap_state_t state;
   tap_state_t next_state;
   logic [LINK_PINS-1:0] pin_raw;
   logic [LINK_PINS-1:0] pin_level;
   logic [LINK_PINS-1:0] pin_rise;
   logic [LINK_PINS-1:0] pin_fall;
   logic tck_rise;
   logic tck_fall;
   logic tms;
   logic tdi;
   logic [IR_WIDTH-1:0] ir_shift;
   logic [IR_WIDTH-1:0] instr;
   logic sel_bsr;
   logic sel_id;
   logic sel_bypass;
   logic bypass_bit;
   logic [ID_WIDTH-1:0] id_shift;
   logic bsr_serial;
   logic bsr_capture;
   logic bsr_shift;
   logic bsr_update;
   logic serial_tap;
   logic tdo;
   logic tdo_oe;

   // ************************************************************
   // Link pin sampling
   // ************************************************************
   assign pin_raw[PIN_TCK] = link_in.tck;
   assign pin_raw[PIN_TMS] = link_in.tms;
   assign pin_raw[PIN_TDI] = link_in.tdi;

   pin_sync #(.WIDTH(LINK_PINS)) u_pin_sync
   (
      .clk(clk),
      .rstn(rstn),
      .raw(pin_raw),
      .level(pin_level),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // TMS and TDI share the TCK delay, so their levels line up with the detected edge.
   assign tck_rise = pin_rise[PIN_TCK];
   assign tck_fall = pin_fall[PIN_TCK];
   assign tms = pin_level[PIN_TMS];
   assign tdi = pin_level[PIN_TDI];

   // ************************************************************
   // Controller state register
   // ************************************************************
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         state <= test_logic_reset;
      end
      else if (tck_rise)
      begin
         state <= next_state;
      end
   end

   assign tap_state = state;

   // ************************************************************
   // Next-state decode, taken on each rising TCK edge
   // ************************************************************
   always_comb
   begin
      next_state = state;
      case (state)
         test_logic_reset:
         begin
            next_state = tms ? test_logic_reset : run_test_idle;
         end
         run_test_idle:
         begin
            if (tms)
            begin
               next_state = select_dr_scan;
            end
            else
            begin
               next_state = run_test_idle;
            end
         end
         select_dr_scan:
         begin
            if (tms)
            begin
               next_state = select_ir_scan;
            end
            else
            begin
               next_state = capture_dr;
            end
         end
         capture_dr:
         begin
            if (tms)
            begin
               next_state = exit1_dr;
            end
            else
            begin
               next_state = shift_dr;
            end
         end
         shift_dr:
         begin
            next_state = tms ? exit1_dr : shift_dr;
         end
         exit1_dr:
         begin
            if (tms)
            begin
               next_state = update_dr;
            end
            else
            begin
               next_state = pause_dr;
            end
         end
         pause_dr:
         begin
            next_state = tms ? exit2_dr : pause_dr;
         end
         exit2_dr:
         begin
            if (tms)
            begin
               next_state = update_dr;
            end
            else
            begin
               next_state = shift_dr;
            end
         end
         update_dr:
         begin
            next_state = tms ? select_dr_scan : run_test_idle;
         end
         select_ir_scan:
         begin
            if (tms)
            begin
               next_state = test_logic_reset;
            end
            else
            begin
               next_state = capture_ir;
            end
         end
         capture_ir:
         begin
            if (tms)
            begin
               next_state = exit1_ir;
            end
            else
            begin
               next_state = shift_ir;
            end
         end
         shift_ir:
         begin
            next_state = tms ? exit1_ir : shift_ir;
         end
         exit1_ir:
         begin
            if (tms)
            begin
               next_state = update_ir;
            end
            else
            begin
               next_state = pause_ir;
            end
         end
         pause_ir:
         begin
            next_state = tms ? exit2_ir : pause_ir;
         end
         exit2_ir:
         begin
            next_state = tms ? update_ir : shift_ir;
         end
         update_ir:
         begin
            next_state = tms ? select_dr_scan : run_test_idle;
         end
         default:
         begin
            next_state = test_logic_reset;
         end
      endcase
   end

   // ************************************************************
   // Instruction shift register
   // ************************************************************
   // Any state other than capture and shift leaves the stages alone.
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         ir_shift <= IR_CAPTURE_VALUE;
      end
      else if (tck_rise && state == capture_ir)
      begin
         ir_shift <= IR_CAPTURE_VALUE;
      end
      else if (tck_rise && state == shift_ir)
      begin
         ir_shift <= {tdi, ir_shift[IR_WIDTH-1:1]};
      end
   end

   // ************************************************************
   // Current instruction
   // ************************************************************
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         instr <= INSTR_IDCODE;
      end
      else if (state == test_logic_reset)
      begin
         instr <= INSTR_IDCODE;
      end
      else if (tck_fall && state == update_ir)
      begin
         instr <= ir_shift;
      end
   end

   // Codes without a register of their own fall back to the bypass bit.
   assign sel_bsr = (instr == INSTR_EXTEST) || (instr == INSTR_SAMPLE);
   assign sel_id = (instr == INSTR_IDCODE);
   assign sel_bypass = !sel_bsr && !sel_id;

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         ext_test <= 1'b0;
      end
      else
      begin
         ext_test <= (instr == INSTR_EXTEST) && (state != test_logic_reset);
      end
   end

   // ************************************************************
   // Bypass and identification registers
   // ************************************************************
   // The bypass bit has no parallel input, so capture leaves it as it was.
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         bypass_bit <= 1'b0;
      end
      else if (tck_rise && state == shift_dr && sel_bypass)
      begin
         bypass_bit <= tdi;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         id_shift <= ID_CODE;
      end
      else if (tck_rise && state == capture_dr && sel_id)
      begin
         id_shift <= ID_CODE;
      end
      else if (tck_rise && state == shift_dr && sel_id)
      begin
         id_shift <= {tdi, id_shift[ID_WIDTH-1:1]};
      end
   end

   // ************************************************************
   // Boundary scan register
   // ************************************************************
   assign bsr_capture = tck_rise && (state == capture_dr) && sel_bsr;
   assign bsr_shift = tck_rise && (state == shift_dr) && sel_bsr;
   assign bsr_update = tck_fall && (state == update_dr) && sel_bsr;

   boundary_scan_reg #(.LENGTH(BSR_BITS)) u_bsr
   (
      .clk(clk),
      .rstn(rstn),
      .capture(bsr_capture),
      .shift(bsr_shift),
      .update(bsr_update),
      .tdi(tdi),
      .pins_in(pins_in),
      .serial_out(bsr_serial),
      .pins_out(pins_out)
   );

   // ************************************************************
   // Serial output
   // ************************************************************
   always_comb
   begin
      if (state == shift_ir)
      begin
         serial_tap = ir_shift[0];
      end
      else if (sel_bsr)
      begin
         serial_tap = bsr_serial;
      end
      else if (sel_id)
      begin
         serial_tap = id_shift[0];
      end
      else
      begin
         serial_tap = bypass_bit;
      end
   end

   // Updating on the falling edge gives the tester half a TCK period of hold after its rising edge.
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         tdo <= 1'b0;
         tdo_oe <= 1'b0;
      end
      else if (tck_fall)
      begin
         tdo <= serial_tap && ((state == shift_dr) || (state == shift_ir));
         tdo_oe <= (state == shift_dr) || (state == shift_ir);
      end
   end

   assign link_out.tdo = tdo;
   assign link_out.tdo_oe = tdo_oe;

   // ************************************************************
   // Parameter checks
   // ************************************************************
   if (BSR_BITS < 2 || ID_CODE[0] != 1'b1)
   begin : g_check
      $error("boundary length below two or identification bit 0 clear");
   end
endmodule

// ### jtag_tap_state_machine_assertions.sv
// Concurrent checks on the ports of the test access port controller.
`timescale 1ns/100ps
module tap_checker
#(
   parameter int BSR_BITS = 98
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire tap_pkg::link_in_t link_in,
   input wire tap_pkg::link_out_t link_out,
   input wire logic [BSR_BITS-1:0] pins_in,
   input wire logic [BSR_BITS-1:0] pins_out,
   input wire logic ext_test,
   input wire tap_pkg::tap_state_t tap_state
);
   import tap_pkg::*;

   logic tck_q;
   logic [2:0] high_run;
   logic [3:0] since_fall;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   always_ff @(posedge clk)
   begin
      tck_q <= link_in.tck;
   end

   // Raw pin edges are used here; the design's filter adds a few cycles, which the windows allow for.
   always_ff @(posedge clk)
   begin
      if (!rstn)
         high_run <= 3'h0;
      else if (link_in.tck && !tck_q)
         high_run <= !link_in.tms ? 3'h0 : ((high_run == 3'h7) ? high_run : high_run + 3'h1);
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
         since_fall <= 4'hf;
      else if (!link_in.tck && tck_q)
         since_fall <= 4'h0;
      else if (since_fall != 4'hf)
         since_fall <= since_fall + 4'h1;
   end

   function automatic tap_state_t next_on(input tap_state_t s, input logic m);
      case (s)
         test_logic_reset: return m ? test_logic_reset : run_test_idle;
         run_test_idle: return m ? select_dr_scan : run_test_idle;
         select_dr_scan: return m ? select_ir_scan : capture_dr;
         capture_dr: return m ? exit1_dr : shift_dr;
         shift_dr: return m ? exit1_dr : shift_dr;
         exit1_dr: return m ? update_dr : pause_dr;
         pause_dr: return m ? exit2_dr : pause_dr;
         exit2_dr: return m ? update_dr : shift_dr;
         update_dr: return m ? select_dr_scan : run_test_idle;
         select_ir_scan: return m ? test_logic_reset : capture_ir;
         capture_ir: return m ? exit1_ir : shift_ir;
         shift_ir: return m ? exit1_ir : shift_ir;
         exit1_ir: return m ? update_ir : pause_ir;
         pause_ir: return m ? exit2_ir : pause_ir;
         exit2_ir: return m ? update_ir : shift_ir;
         default: return m ? select_dr_scan : run_test_idle;
      endcase
   endfunction

   sequence s_five_high;
      $rose(high_run == 3'h5);
   endsequence

   sequence s_step(logic m);
      $changed(tap_state) && ($past(link_in.tms, 2) == m);
   endsequence

   a_reset_entry: assert property ($rose(rstn) |-> tap_state == test_logic_reset && link_out == '0 && !ext_test)
      else $error("Controller not in reset state after reset release.");
   a_step_mode_low: assert property (s_step(1'b0) |-> tap_state == next_on($past(tap_state), 1'b0))
      else $error("Wrong state step with mode low.");
   a_step_mode_high: assert property (s_step(1'b1) |-> tap_state == next_on($past(tap_state), 1'b1))
      else $error("Wrong state step with mode high.");
   a_reach_reset: assert property (s_five_high |-> ##[1:6] tap_state == test_logic_reset)
      else $error("Five high mode rises did not reach reset state.");
   a_oe_only_shift: assert property (link_out.tdo_oe |-> tap_state inside {shift_dr, shift_ir, exit1_dr, exit1_ir})
      else $error("Serial output enabled outside a shift.");
   a_tdo_idle_low: assert property (!link_out.tdo_oe |-> !link_out.tdo)
      else $error("Serial output not low while disabled.");
   a_out_on_fall: assert property ($changed(link_out) |-> since_fall inside {[4'h2:4'h5]})
      else $error("Serial output changed away from a falling test clock.");
   a_latch_in_update: assert property ($changed(pins_out) |-> tap_state == update_dr)
      else $error("Parallel output changed outside update.");
   a_ext_in_reset: assert property (tap_state == test_logic_reset [*2] |-> !ext_test)
      else $error("Test logic enabled in reset state.");
   a_instr_moment: assert property ($changed(ext_test) |-> tap_state inside {update_ir, test_logic_reset})
      else $error("Instruction changed outside update or reset.");
endmodule

bind jtag_tap_state_machine tap_checker #(.BSR_BITS(BSR_BITS)) i_checker
(
   .clk(clk),
   .rstn(rstn),
   .link_in(link_in),
   .link_out(link_out),
   .pins_in(pins_in),
   .pins_out(pins_out),
   .ext_test(ext_test),
   .tap_state(tap_state)
);

// ### jtag_tester.sv
// Model of the external tester that drives the test clock, mode and data pins.
`timescale 1ns/100ps
module jtag_tester
(
   input wire logic clk,
   output tap_pkg::link_in_t link_in,
   input wire tap_pkg::link_out_t link_out
);
   import tap_pkg::*;

   logic last_tdi;

   initial
   begin
      link_in = '0;
      last_tdi = 1'b0;
   end

   // Pins change with the falling test clock, so they sit still four cycles before each rise.
   // Entered on a falling system clock edge; output is read just before the next falling test clock.
   task automatic clock_bit(input logic mode, input logic data, output logic seen);
      link_in.tck <= 1'b0;
      link_in.tms <= mode;
      link_in.tdi <= data;
      last_tdi = data;
      repeat (4) @(negedge clk);
      link_in.tck <= 1'b1;
      repeat (4) @(negedge clk);
      seen = link_out.tdo;
   endtask

   // The test clock is parked low between frames.
   task automatic park();
      link_in.tck <= 1'b0;
      repeat (4) @(negedge clk);
   endtask

   // Unused data bits toggle so that a stale level is never mistaken for a shifted one.
   task automatic scan(input logic to_ir, input logic [127:0] din, input int n, output logic [127:0] dout);
      logic seen;
      dout = '0;
      clock_bit(1'b1, ~last_tdi, seen);
      if (to_ir)
         clock_bit(1'b1, ~last_tdi, seen);
      clock_bit(1'b0, ~last_tdi, seen);
      clock_bit(1'b0, ~last_tdi, seen);
      for (int i = 0; i < n; i++)
      begin
         clock_bit(i == n - 1, din[i], seen);
         dout[i] = seen;
      end
      clock_bit(1'b1, ~last_tdi, seen);
      clock_bit(1'b0, ~last_tdi, seen);
      park();
   endtask

   task automatic reset_five();
      logic seen;
      repeat (5) clock_bit(1'b1, ~last_tdi, seen);
      park();
   endtask
endmodule

// ### jtag_tap_state_machine_bench.sv
// Self-checking bench for the test access port controller, driven through the tester model.
`timescale 1ns/100ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
   $display("MISMATCH at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module jtag_tap_state_machine_bench;
   import tap_pkg::*;

   // Arbitrary identification value; bit 0 stays set.
   localparam logic [31:0] ID = 32'h2468_ace1;
   localparam logic [97:0] PAT_A = {2'h2, {3{32'hc3a5_1e69}}};
   localparam logic [97:0] PAT_B = ~PAT_A;

   logic clk;
   logic rstn;
   link_in_t link_in;
   link_out_t link_out;
   logic [97:0] pins_in;
   logic [97:0] pins_out;
   logic ext_test;
   tap_state_t tap_state;
   logic [127:0] dout;
   logic seen;
   int n_errors = 0;
   int n_tests = 0;

   jtag_tap_state_machine #(.BSR_BITS(BSR_LENGTH), .ID_CODE(ID)) i_dut
   (
      .clk(clk),
      .rstn(rstn),
      .link_in(link_in),
      .link_out(link_out),
      .pins_in(pins_in),
      .pins_out(pins_out),
      .ext_test(ext_test),
      .tap_state(tap_state)
   );

   jtag_tester tst
   (
      .clk(clk),
      .link_in(link_in),
      .link_out(link_out)
   );

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // ************************************************************
   // Helpers
   // ************************************************************
   task automatic set_pins(input logic [97:0] v);
      @(posedge clk);
      pins_in <= v;
      @(negedge clk);
   endtask

   task automatic to_idle();
      tst.clock_bit(1'b0, 1'b0, seen);
      tst.park();
   endtask

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_power_up();
      `CHK(tap_state, test_logic_reset)
      `CHK(link_out, 2'h0)
      `CHK(ext_test, 1'b0)
      to_idle();
      tst.scan(1'b0, '0, 32, dout);
      `CHK(dout[31:0], ID)
      `CHK(pins_out, 98'h0)
      $display("Test power_up done");
   endtask

   task automatic t_ir_capture();
      tst.scan(1'b1, 128'(INSTR_SAMPLE), 3, dout);
      `CHK(dout[2:0], IR_CAPTURE_VALUE)
      `CHK(ext_test, 1'b0)
      $display("Test ir_capture done");
   endtask

   task automatic t_sample();
      set_pins(PAT_A);
      tst.scan(1'b0, 128'(PAT_B), 98, dout);
      `CHK(dout[97:0], PAT_A)
      `CHK(pins_out, PAT_B)
      $display("Test sample done");
   endtask

   task automatic t_walk();
      logic [22:0] walk_tms;
      tap_state_t exp_st [23];
      walk_tms = 23'b01010010011110101101110;
      exp_st = '{run_test_idle, select_dr_scan, capture_dr, exit1_dr, pause_dr, pause_dr, exit2_dr,
                 shift_dr, shift_dr, exit1_dr, update_dr, select_dr_scan, select_ir_scan, capture_ir,
                 exit1_ir, pause_ir, exit2_ir, update_ir, run_test_idle, select_dr_scan, select_ir_scan,
                 test_logic_reset, run_test_idle};
      for (int i = 0; i < 23; i++)
      begin
         tst.clock_bit(walk_tms[22 - i], i[0], seen);
         `CHK(tap_state, exp_st[i])
         if (i == 5)
            `CHK(pins_out, PAT_B)
      end
      tst.park();
      $display("Test walk done");
   endtask

   task automatic t_extest_bypass();
      tst.scan(1'b1, 128'(INSTR_EXTEST), 3, dout);
      `CHK(ext_test, 1'b1)
      set_pins(PAT_B);
      tst.scan(1'b0, 128'(PAT_A), 98, dout);
      `CHK(dout[97:0], PAT_B)
      `CHK(pins_out, PAT_A)
      tst.scan(1'b1, 128'(INSTR_BYPASS), 3, dout);
      `CHK(ext_test, 1'b0)
      tst.scan(1'b0, 128'h5, 3, dout);
      `CHK(dout[2:1], 2'h1)
      `CHK(pins_out, PAT_A)
      $display("Test extest_bypass done");
   endtask

   task automatic t_five_high();
      tst.clock_bit(1'b1, 1'b0, seen);
      tst.clock_bit(1'b0, 1'b1, seen);
      tst.clock_bit(1'b0, 1'b0, seen);
      `CHK(tap_state, shift_dr)
      tst.reset_five();
      `CHK(tap_state, test_logic_reset)
      tst.clock_bit(1'b1, 1'b1, seen);
      `CHK(tap_state, test_logic_reset)
      to_idle();
      tst.scan(1'b0, '0, 32, dout);
      `CHK(dout[31:0], ID)
      $display("Test five_high done");
   endtask

   // ************************************************************
   // Sequence and watchdog
   // ************************************************************
   initial
   begin
      rstn = 1'b0;
      pins_in = '0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      t_power_up();
      t_ir_capture();
      t_sample();
      t_walk();
      t_extest_bypass();
      t_five_high();
      give_verdict();
   end

   // The scenarios need about 2900 cycles; over four times that is a hang.
   initial
   begin
      #250000;
      n_errors++;
      give_verdict();
   end
endmodule
